//--- include/ppc_pkg.sv
// Shared constants for the port B/C/D control/status register bank
package ppc_pkg;

   // Register index on the register port (one 16-bit word each)
   localparam logic [1:0] PPC_IDX_PORT_A = 2'h0;
   localparam logic [1:0] PPC_IDX_PORT_B = 2'h1;
   localparam logic [1:0] PPC_IDX_PORT_C = 2'h2;
   localparam logic [1:0] PPC_IDX_PORT_D = 2'h3;

   // Position of the group select and latched address bit two within the index
   localparam int PPC_IDX_GROUP_BIT = 1;
   localparam int PPC_IDX_ADDR2_BIT = 0;

   // Field layout of a port control/status word
   localparam int PPC_LOW_MSB    = 7;
   localparam int PPC_LOW_LSB    = 0;
   localparam int PPC_DIR_BIT    = 8;
   localparam int PPC_RDY_BIT    = 15;
   localparam int PPC_UNUSED_W   = 6;
   localparam logic [PPC_UNUSED_W-1:0] PPC_UNUSED_VAL = 6'h00;

   // Byte lanes
   localparam int PPC_BE_LOW  = 0;
   localparam int PPC_BE_HIGH = 1;

   // Number of ports with direction logic (B, C, D)
   localparam int PPC_NPORT = 3;

   // Reset values
   localparam logic       PPC_DIR_RST  = 1'b0;
   localparam logic [7:0] PPC_BYTE_RST = 8'h00;
   localparam logic [15:0] PPC_WORD_RST = 16'h0000;

endpackage

//--- design/ppc_csr_bank.sv
// Contract
// R1: Port B low byte is group 1 data path.
// R2: Data path reaches request, service, clear, mask, vectors.
// R3: Port B low byte survives bus initialize.
// R4: Port C low byte: group 2 status/command.
// R5: Port D low byte is group 2 data path.
// R6: Ports B, C, D own direction and ready bits.
// R7: Direction zero asserts ready out, input role.
// R8: Drive only when direction and user ready.
// R9: Either negated keeps data drivers high-impedance.
// R10: Bus initialize clears every direction bit.
// R11: Bit 15 reads live user-ready level.
// R12: User device raises ready to request output.
// R13: Bus initialize leaves user-ready status alone.
// R14: Port A low byte: group 1 status/command.
// R15: Address bit two picks control or data port.
// R16: Bits 14 to 9 read zero, ignore writes.
//
// Overview
// Register indices 0..3 reach ports A..D. Index bit one picks the
// controller group, and index bit zero stands for latched address bit two.
// That bit picks the control port (A, C) or the data port (B, D).
// Only the low byte of A is handled here. Its high bits belong to
// another bank, so a high-lane write to index 0 is dropped.
//
// Word layout of ports B..D
//   15     user-ready status, read only, live level
//   14:9   unused, read zero, writes dropped
//   8      direction: 0 input role, 1 output role once user ready
//   7:0    controller byte (control port on C, data port on B and D)
//
// Timing, counted from the edge that takes a request
//   Write: the controller strobe and the direction bit move one edge later.
//   Ready out and drive enable move at that same edge, fed from next values.
//   Read: the controller strobe comes one edge later, and the answer word
//   two edges later. The answer is valid for exactly one cycle.
//
// Hazards
//   A read and a low-lane write in one cycle: only the read reaches the
//   controller, since one strobe pair cannot carry both.
//   Bus initialize and a direction write in one cycle: initialize wins,
//   and the port ends up in the input role.
//   The user-ready pins are asynchronous. They pass three flops and count
//   only when the last two agree, so the status bit and the drive enable
//   lag a pin change by about four edges. A user device must allow for
//   that before it expects data on its lines.
//   The controller read byte must settle within the strobe cycle. A slow
//   controller would need a wait state, and this bank does not provide one.
//
// Trade-offs
//   Drive enable is built from next values, so it needs no extra cycle
//   against ready out. The cost is a wider cone in front of each flop.
`timescale 1ns/1ps
`default_nettype none

module ppc_csr_bank
   import ppc_pkg::*;
(
   input  wire  logic                 sys_clk,          // 50 MHz bus clock
   input  wire  logic                 srst,             // Synchronous reset, active high
   input  wire  logic                 busInitialize,    // Bus initialize pulse, same clock
   input  wire  logic                 regWrite,         // Register write strobe
   input  wire  logic                 regRead,          // Register read strobe
   input  wire  logic [1:0]           regIndex,         // A, B, C or D
   input  wire  logic [1:0]           regByteEn,        // Byte enables, bit 0 low byte
   input  wire  logic [15:0]          regWrData,        // Write word
   output logic       [15:0]          regRdData,        // Read word, registered
   output logic                       regRdValid,       // One-cycle read answer
   output logic                       ctlWrite,         // Controller write strobe
   output logic                       ctlRead,          // Controller read strobe
   output logic                       ctlGroup,         // 0 group 1, 1 group 2
   output logic                       ctlDataPort,      // Latched address bit two
   output logic       [7:0]           ctlWrData,        // Byte to controller
   input  wire  logic [7:0]           ctlRdData,        // Byte from controller, same clock
   input  wire  logic [PPC_NPORT-1:0] userReady,        // User ready pins, B..D
   output logic       [PPC_NPORT-1:0] interfaceReadyOut, // Ready toward user, B..D
   output logic       [PPC_NPORT-1:0] portDriveEnable   // Data driver enable, B..D
);

   // Decoded request fields
   wire logic          lowByteWr;      // Low byte written this cycle
   wire logic          highByteWr;     // High byte written this cycle
   wire logic          isDirPort;      // Request targets B, C or D
   wire logic [1:0]    dirSlot;        // 0..2 slot of B..D
   wire logic          ctlTouch;       // Request reaches a controller

   assign lowByteWr  = regWrite & regByteEn[PPC_BE_LOW];
   assign highByteWr = regWrite & regByteEn[PPC_BE_HIGH];
   assign isDirPort  = (regIndex != PPC_IDX_PORT_A);
   // Meaningful only for B..D; port A wraps to an unused slot
   assign dirSlot    = regIndex - PPC_IDX_PORT_B;
   // A read always reaches the controller; a write only with the low lane
   assign ctlTouch   = regRead | lowByteWr;

   // Per port state
   logic [PPC_NPORT-1:0] dir_reg;      // Direction bits
   logic [PPC_NPORT-1:0] dir_next;
   logic [PPC_NPORT-1:0] syncA_reg;    // First synchroniser stage
   logic [PPC_NPORT-1:0] syncB_reg;    // Second stage
   logic [PPC_NPORT-1:0] syncC_reg;    // Third stage
   logic [PPC_NPORT-1:0] rdyLive_reg;  // Filtered user-ready level
   logic [PPC_NPORT-1:0] rdyLive_next;

   genvar g;
   generate
      for (g = 0; g < PPC_NPORT; g++) begin : gPort
         // Direction bit; initialize beats a write in the same cycle
         assign dir_next[g] = busInitialize ? PPC_DIR_RST :                           // R10
                              (highByteWr && isDirPort && dirSlot == 2'(g)) ?
                              regWrData[PPC_DIR_BIT] : dir_reg[g];                     // R6
         // Level counts once the two last stages agree; initialize plays no part
         assign rdyLive_next[g] = (syncB_reg[g] == syncC_reg[g]) ?
                                  syncC_reg[g] : rdyLive_reg[g];                       // R13

         // Direction, synchroniser and port outputs
         // Only the second stage reads the first, so a metastable first
         // stage never reaches the filter or the outputs
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               dir_reg[g]           <= PPC_DIR_RST;
               syncA_reg[g]         <= 1'b0;
               syncB_reg[g]         <= 1'b0;
               syncC_reg[g]         <= 1'b0;
               rdyLive_reg[g]       <= 1'b0;
               interfaceReadyOut[g] <= ~PPC_DIR_RST;
               portDriveEnable[g]   <= 1'b0;
            end else begin
               dir_reg[g]           <= dir_next[g];
               syncA_reg[g]         <= userReady[g];
               syncB_reg[g]         <= syncA_reg[g];
               syncC_reg[g]         <= syncB_reg[g];
               rdyLive_reg[g]       <= rdyLive_next[g];
               interfaceReadyOut[g] <= ~dir_next[g];                                   // R7
               // Outputs stay high-impedance unless both are true
               portDriveEnable[g]   <= dir_next[g] & rdyLive_next[g];                  // R8 R9
            end
         end
      end
   endgenerate

   // Controller access stage: strobes leave a flop one cycle after the request
   // Group, port select and byte hold between accesses, so the controller
   // sees steady inputs; only the strobes are single-cycle pulses
   logic          rdPend_reg;          // Read waiting for controller byte
   logic [1:0]    rdIdx_reg;           // Index of that read

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctlWrite    <= 1'b0;
         ctlRead     <= 1'b0;
         ctlGroup    <= 1'b0;
         ctlDataPort <= 1'b0;
         ctlWrData   <= PPC_BYTE_RST;
         rdPend_reg  <= 1'b0;
         rdIdx_reg   <= PPC_IDX_PORT_A;
      end else begin
         // Initialize never reaches the controllers, so their bytes persist
         ctlWrite    <= lowByteWr & ~regRead;                                          // R3
         ctlRead     <= regRead;                                                       // R4 R14
         rdPend_reg  <= regRead;
         if (ctlTouch) begin
            ctlGroup    <= regIndex[PPC_IDX_GROUP_BIT];                                // R4 R14
            ctlDataPort <= regIndex[PPC_IDX_ADDR2_BIT];                                // R15 R1 R5 R2
            ctlWrData   <= regWrData[PPC_LOW_MSB:PPC_LOW_LSB];
            rdIdx_reg   <= regIndex;
         end
      end
   end

   // Read word assembly from the controller byte and port state
   // The status bit is the filtered level, not the raw pin, so a read can
   // never return a value caught in the middle of a pin change
   wire logic [1:0]  rdSlot;           // Slot of the pending read
   wire logic        rdIsDir;          // Pending read has direction bits
   wire logic [15:0] rdWord;           // Word to return

   assign rdSlot  = rdIdx_reg - PPC_IDX_PORT_B;
   assign rdIsDir = (rdIdx_reg != PPC_IDX_PORT_A);
   // Unused bits always zero; port A high byte is outside this bank
   assign rdWord  = rdIsDir ?
                    {rdyLive_reg[rdSlot], PPC_UNUSED_VAL, dir_reg[rdSlot], ctlRdData} :  // R11 R16
                    {8'h00, ctlRdData};

   // Read answer register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regRdData  <= PPC_WORD_RST;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= rdPend_reg;
         if (rdPend_reg) begin
            regRdData <= rdWord;
         end
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_init_clears_dir: assert property (                                                // R10
      busInitialize |=> (dir_reg == '0) && (interfaceReadyOut == '1))
      else $error("direction not cleared by initialize");
   a_drive_needs_both: assert property (                                               // R8
      ##1 (portDriveEnable == (dir_reg & rdyLive_reg)))
      else $error("drive enable does not match direction and ready");
   a_hiz_when_negated: assert property (                                               // R9
      (busInitialize || (rdyLive_next == '0)) |=> (portDriveEnable == '0))
      else $error("drivers enabled while a condition is negated");
   a_ready_out_dir: assert property (                                                  // R7
      ##1 (interfaceReadyOut == ~dir_reg))
      else $error("ready out does not follow direction");
   a_init_no_write: assert property (                                                  // R3
      (busInitialize && !regWrite) |=> !ctlWrite)
      else $error("initialize disturbed a controller byte");
   a_read_two_cycles: assert property (                                                // R4
      regRead |=> ctlRead ##1 (regRdValid && $past(ctlRead)))
      else $error("read answer not two cycles after request");
   a_addr2_select: assert property (                                                   // R15
      regRead |=> (ctlDataPort == $past(regIndex[PPC_IDX_ADDR2_BIT]))
                  && (ctlGroup == $past(regIndex[PPC_IDX_GROUP_BIT])))
      else $error("control or data port selected wrongly");
   a_unused_zero: assert property (                                                    // R16
      regRdValid |-> (regRdData[PPC_RDY_BIT-1:PPC_DIR_BIT+1] == PPC_UNUSED_VAL))
      else $error("unused bits not zero");
   a_ready_status_live: assert property (                                              // R11
      (regRdValid && $past(rdIsDir)) |->
         regRdData[PPC_RDY_BIT] == $past(rdyLive_reg[rdSlot]))
      else $error("ready status bit not live level");
   a_ready_keeps_init: assert property (                                               // R13
      (busInitialize && syncB_reg == syncC_reg) |=> rdyLive_reg == $past(syncC_reg))
      else $error("initialize disturbed ready status");

   // Controller path: strobes, selects and bytes
   // A low-lane write alone reaches the controller one edge later
   a_write_byte_pass: assert property (                                                // R5
      (lowByteWr && !regRead) |=>
         ctlWrite && (ctlWrData == $past(regWrData[PPC_LOW_MSB:PPC_LOW_LSB])))
      else $error("controller byte or strobe lost on write");

   // The group follows index bit one on every low-lane write
   a_write_group_sel: assert property (                                                // R14
      lowByteWr |=> (ctlGroup == $past(regIndex[PPC_IDX_GROUP_BIT])))
      else $error("controller group wrong on write");

   // A read suppresses the write strobe of the same cycle
   a_read_blocks_write: assert property (                                              // R4
      regRead |=> !ctlWrite)
      else $error("write strobe issued alongside a read");

   // No read strobe without a request one edge before
   a_ctl_read_cause: assert property (                                                 // R1
      ctlRead |-> $past(regRead))
      else $error("controller read strobe without request");

   // Low byte of every answer is the byte the controller showed
   a_low_byte_read: assert property (                                                  // R2
      regRdValid |-> (regRdData[PPC_LOW_MSB:PPC_LOW_LSB] == $past(ctlRdData)))
      else $error("answer low byte differs from controller byte");

   // Initialize leaves the controller inputs alone
   a_init_keeps_ctl: assert property (                                                 // R3
      (busInitialize && !ctlTouch) |=>
         $stable(ctlWrData) && $stable(ctlGroup) && $stable(ctlDataPort))
      else $error("initialize moved controller inputs");

   // Direction bits: writes land, port A writes do not
   // A high-lane write to B..D lands in that port's direction bit
   a_dir_write_lands: assert property (                                                // R6
      (highByteWr && isDirPort && !busInitialize) |=>
         (dir_reg[$past(dirSlot)] == $past(regWrData[PPC_DIR_BIT])))
      else $error("direction write did not land");

   // A high-lane write to port A changes no direction bit here
   a_porta_high_keep: assert property (                                                // R6
      (highByteWr && !isDirPort && !busInitialize) |=> $stable(dir_reg))
      else $error("port A write changed a direction bit");

   // Port A answers carry a zero high byte
   a_porta_high_zero: assert property (                                                // R14
      (regRdValid && !$past(rdIsDir)) |->
         (regRdData[PPC_RDY_BIT:PPC_DIR_BIT] == PPC_BYTE_RST))
      else $error("port A answer high byte not zero");

   // Drive enable only where the status bit is up
   a_drive_needs_ready: assert property (                                              // R9
      ##1 ((portDriveEnable & ~rdyLive_reg) == '0))
      else $error("driver enabled without user ready");

   // Main scenarios seen
   c_output_role: cover property (portDriveEnable != '0);
   c_init_clear:  cover property ((dir_reg != '0) ##1 busInitialize ##1 (dir_reg == '0));
   c_data_write:  cover property (ctlWrite && ctlDataPort);
   c_status_read: cover property (regRdValid && regRdData[PPC_RDY_BIT]);
   c_group2_ctl:  cover property (ctlRead && ctlGroup && !ctlDataPort);

endmodule

`default_nettype wire

//--- testbench/ppc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for both interrupt controllers: one byte per group and port
module ppc_ctl_model
(
   input  wire  logic       sys_clk,
   input  wire  logic       ctlWrite,
   input  wire  logic       ctlRead,
   input  wire  logic       ctlGroup,
   input  wire  logic       ctlDataPort,
   input  wire  logic [7:0] ctlWrData,
   output logic       [7:0] ctlRdData
);
   logic      [7:0] store [4];                  // Control and data bytes, both groups
   wire logic [1:0] sel = {ctlGroup, ctlDataPort}; // Group, then control or data port
   initial foreach (store[i]) store[i] = 8'h00;
   // Each byte lands in its own place
   always @(posedge sys_clk) begin
      if (ctlWrite) begin
         store[sel] <= ctlWrData;
      end
   end
   // Outside a read the bus shows the inverse, so a late sample is caught
   assign ctlRdData = ctlRead ? store[sel] : ~store[sel];
endmodule
`default_nettype wire

//--- testbench/parallel_port_csr_bcd_bench.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_port_csr_bcd_bench;
   import ppc_pkg::*;
   logic sys_clk = 0, srst = 1, busInitialize = 0, regWrite = 0, regRead = 0;
   logic [1:0]  regIndex = 0, regByteEn = 0;
   logic [15:0] regWrData = 0, regRdData, q;
   logic        regRdValid, ctlWrite, ctlRead, ctlGroup, ctlDataPort;
   logic [7:0]  ctlWrData, ctlRdData, eByte [4];   // Expected controller bytes
   logic [2:0]  userReady = 0, interfaceReadyOut, portDriveEnable, eDir = 0;
   int          n_mismatch = 0, checks = 0, cyc = 0;
   always #10 sys_clk = ~sys_clk;                   // 50 MHz
   ppc_csr_bank dut (.sys_clk(sys_clk), .srst(srst), .busInitialize(busInitialize),
      .regWrite(regWrite), .regRead(regRead), .regIndex(regIndex), .regByteEn(regByteEn),
      .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .ctlWrite(ctlWrite), .ctlRead(ctlRead), .ctlGroup(ctlGroup),
      .ctlDataPort(ctlDataPort), .ctlWrData(ctlWrData), .ctlRdData(ctlRdData),
      .userReady(userReady), .interfaceReadyOut(interfaceReadyOut),
      .portDriveEnable(portDriveEnable));
   ppc_ctl_model far (.sys_clk(sys_clk), .ctlWrite(ctlWrite), .ctlRead(ctlRead),
      .ctlGroup(ctlGroup), .ctlDataPort(ctlDataPort), .ctlWrData(ctlWrData),
      .ctlRdData(ctlRdData));
   task automatic results();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard: stops at 3000 cycles, many times the traffic of under a hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One write; the high lane only reaches direction bits of B..D
   task automatic wr(input logic [1:0] idx, input logic [1:0] be, input logic [15:0] d);
      @(posedge sys_clk);
      regWrite <= 1;
      regIndex <= idx;
      regByteEn <= be;
      regWrData <= d;
      @(posedge sys_clk);
      regWrite <= 0;
      if (be[0]) eByte[idx] = d[7:0];
      if (be[1] && idx != 0) eDir[idx-1] = d[PPC_DIR_BIT];
      @(negedge sys_clk);
   endtask
   // One read, answer awaited under a bound and checked against the expected word
   task automatic rd(input logic [1:0] idx);
      int n;
      @(posedge sys_clk);
      regRead <= 1;
      regIndex <= idx;
      @(posedge sys_clk);
      regRead <= 0;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (regRdValid !== 1'b1 && n < 4);
      chk(16'(n), 16'h2);
      if (idx == 0) chk(regRdData, {8'h00, eByte[0]});
      else chk(regRdData, {userReady[idx-1], PPC_UNUSED_VAL, eDir[idx-1], eByte[idx]});
   endtask
   // Both groups, both ports: four separate bytes come back
   task automatic t_paths();
      for (int i = 0; i < 4; i++) wr(2'(i), 2'h1, 16'hFF00 | 16'(8'hA0 + i));
      for (int i = 0; i < 4; i++) rd(2'(i));
   endtask
   // Direction set with no user ready: nothing drives
   task automatic t_dir();
      for (int i = 1; i < 4; i++) wr(2'(i), 2'h3, 16'h7F50 | 16'(i));
      chk(16'(interfaceReadyOut), 16'h0);
      chk(16'(portDriveEnable), 16'h0);
      @(posedge sys_clk);
      userReady <= 3'b101;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(16'(portDriveEnable), 16'h5);
      wr(2'h2, 2'h2, 16'h0000);
      chk(16'(interfaceReadyOut), 16'h2);
      for (int i = 1; i < 4; i++) rd(2'(i));
   endtask
   // Bus initialize clears only the direction bits
   task automatic t_init();
      @(posedge sys_clk);
      busInitialize <= 1;
      @(posedge sys_clk);
      busInitialize <= 0;
      eDir = 0;
      @(negedge sys_clk);
      chk(16'(interfaceReadyOut), 16'h7);
      chk(16'(portDriveEnable), 16'h0);
      for (int i = 0; i < 4; i++) rd(2'(i));
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      srst <= 0;
      @(posedge sys_clk);
      t_paths();
      t_dir();
      t_init();
      results();
   end
endmodule
`default_nettype wire
